// File: src/fsrs_fifo.sv
// Flip-flop FIFO for sector data on its way to the host
`timescale 1ns/1ns
module fsrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic arst_n_in,
  // Stream ports
  fsrs_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // Honest flags: full refuses, empty shows nothing
  assign f.wr_ready = (cnt_r != (AW+1)'(DEPTH));
  assign f.rd_valid = (cnt_r != '0);
  assign f.rd_data  = mem_r[rp_r];
  assign push       = f.wr_valid & f.wr_ready;
  assign pop        = f.rd_ready & f.rd_valid;

  // Pointer and storage update
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    if (push) begin
      mem_nxt[wp_r] = f.wr_data;
      wp_nxt        = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // fsrs_fifo

// File: src/fsrs_fifo_if.sv
// Byte stream carrier between sequencer and FIFO
`timescale 1ns/1ns
interface fsrs_fifo_if;
  logic       wr_valid;
  logic       wr_ready;
  logic [7:0] wr_data;
  logic       rd_valid;
  logic       rd_ready;
  logic [7:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface

// File: src/fsrs_map.svh
// Constants of the floppy sector read sequencer
`ifndef FSRS_MAP_SVH
`define FSRS_MAP_SVH
`define FSRS_CMD_LEN     4'h9
`define FSRS_RES_LAST    3'h6
`define FSRS_BIT_MT      7
`define FSRS_BIT_SK      5
`define FSRS_OP_MASK     8'h1F
`define FSRS_OP_RD_DEL   5'h0C
`define FSRS_IC_ABN      2'h1
`define FSRS_SEC_BASE    15'h0080
`define FSRS_SEC_FIRST   8'h01
`define FSRS_CLK_NS      40
`define FSRS_TICK_NS     1000000
`define FSRS_FIFO_DEPTH  8
`define FSRS_ST1_EN      7
`define FSRS_ST1_DE      5
`define FSRS_ST1_OR      4
`define FSRS_ST1_ND      2
`define FSRS_ST2_CM      6
`define FSRS_ST2_DD      5
`endif

// File: src/fsrs_pkg.sv
// Types of the floppy sector read sequencer
package fsrs_pkg;
  typedef enum logic [7:0] {
    fsrs_st_idle   = 8'h01,
    fsrs_st_cmd    = 8'h02,
    fsrs_st_seek   = 8'h04,
    fsrs_st_settle = 8'h08,
    fsrs_st_search = 8'h10,
    fsrs_st_data   = 8'h20,
    fsrs_st_skip   = 8'h40,
    fsrs_st_result = 8'h80
  } fsrs_state_t;
endpackage

// File: src/fsrs_seq.sv
// Read data sequencer: command, implied seek, settle, search, transfer
//
// Operation
// - Read, write, verify share parameters and results; low 5 bits differ.
// - With implied seek enabled, seek runs inside the transfer command.
// - Drive busy bit stands for the selected drive during the seek.
// - Failed seek reports error in status zero, cylinder of failure.
// - Load head if unloaded, wait settle time, then scan ID fields.
// - Matching ID field: read its data field into the FIFO.
// - After each sector increment sector number and read the next.
// - Terminal count or overrun stops delivery; sector and CRC still end.
// - Sector size is 128 shifted left by the size code.
// - Size code zero: deliver only data length bytes, read whole sector.
// - Nonzero size code: data length byte is ignored.
// - Multi-track continues from side 0 through the last sector on side 1.
// - Result ID bytes follow multi-track bit and last sector number.
// - Head stays loaded for unload time; quick next command skips settle.
// - Two index pulses without the sector: abnormal end, no-data flag.
// - CRC error: abnormal end, data error, ID CRC flag for ID fields.
// - Read data: deleted mark reads and halts, or skips with bypass.
// - Read deleted: same with normal and deleted marks swapped.
`timescale 1ns/1ns
`include "fsrs_map.svh"
module fsrs_seq #(
  parameter int TICK_CYC = `FSRS_TICK_NS / `FSRS_CLK_NS
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  // Host command and data port
  input  wire logic       cmd_wr_in,
  input  wire logic [7:0] cmd_byte_in,
  input  wire logic       host_rd_in,
  output logic      [7:0] host_data_out,
  output logic            host_rqm_out,
  output logic            cmd_busy_out,
  output logic      [3:0] drive_busy_out,
  // Configuration
  input  wire logic       implied_seek_en_in,
  input  wire logic [7:0] settle_ms_in,
  input  wire logic [7:0] unload_ms_in,
  // Drive pins
  input  wire logic       index_pulse_in,
  input  wire logic       terminal_count_in,
  output logic            head_load_out,
  // Seek engine
  output logic            seek_req_out,
  output logic      [7:0] seek_cyl_out,
  input  wire logic       seek_done_in,
  input  wire logic       seek_fail_in,
  input  wire logic [7:0] seek_cur_cyl_in,
  // Field decoder
  input  wire logic       id_valid_in,
  input  wire logic       id_crc_ok_in,
  input  wire logic [7:0] id_cyl_in,
  input  wire logic [7:0] id_head_in,
  input  wire logic [7:0] id_sec_in,
  input  wire logic [7:0] id_size_in,
  input  wire logic       dam_valid_in,
  input  wire logic       dam_deleted_in,
  input  wire logic       dat_valid_in,
  input  wire logic [7:0] dat_byte_in,
  input  wire logic       dat_end_in,
  input  wire logic       dat_crc_ok_in,
  // Status
  output logic      [7:0] status_reg_zero_out,
  output logic      [7:0] status_reg_one_out,
  output logic      [7:0] status_reg_two_out
);
  fsrs_pkg::fsrs_state_t st_r, st_nxt;
  logic [7:0]  cmd0_r, cmd0_nxt, sel_r, sel_nxt, cyl_r, cyl_nxt;
  logic [7:0]  hd_r, hd_nxt, sec_r, sec_nxt, size_r, size_nxt;
  logic [7:0]  eot_r, eot_nxt, dtl_r, dtl_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic [2:0]  res_r, res_nxt;
  logic [14:0] bcnt_r, bcnt_nxt, sec_bytes;
  logic [1:0]  ic_r, ic_nxt;
  logic        seek_end_r, seek_end_nxt;
  logic [7:0]  st1_r, st1_nxt, st2_r, st2_nxt;
  logic        found_r, found_nxt, halt_r, halt_nxt, stop_r, stop_nxt;
  logic        idxc_r, idxc_nxt, loaded_r, loaded_nxt;
  logic        mt, sk, want_del, deliver;
  logic        seek_req, settle_go, unload_go;
  logic        settle_done, unload_done;
  logic [14:0] pre_r, pre_nxt;
  logic        tick;
  logic [2:0]  idx_sy_r, tc_sy_r;
  logic        idx_f_r, idx_f_nxt, tc_f_r, tc_f_nxt, idx_edge;
  logic [7:0]  res_byte;
  fsrs_fifo_if ff ();

  // Three-stage synchronisers; filtered level moves once stages 2 and 3 agree
  always_comb begin
    idx_f_nxt = (idx_sy_r[1] == idx_sy_r[2]) ? idx_sy_r[2] : idx_f_r;
    tc_f_nxt  = (tc_sy_r[1] == tc_sy_r[2]) ? tc_sy_r[2] : tc_f_r;
  end
  assign idx_edge = idx_f_nxt & ~idx_f_r;

  // Millisecond prescaler for settle and unload timers
  always_comb begin
    tick    = (pre_r == 15'(TICK_CYC - 1));
    pre_nxt = tick ? 15'h0000 : pre_r + 15'h0001;
  end

  // Command fields
  assign mt        = cmd0_r[`FSRS_BIT_MT];
  assign sk        = cmd0_r[`FSRS_BIT_SK];
  assign want_del  = ((cmd0_r & `FSRS_OP_MASK) ==
                      {3'h0, `FSRS_OP_RD_DEL});
  assign sec_bytes = `FSRS_SEC_BASE << size_r[2:0];

  // Head timers: settle after loading, unload after the command ends
  fsrs_timer u_settle (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (tick),
    .start_in    (settle_go),
    .cancel_in   (1'b0),
    .load_in     (settle_ms_in),
    .busy_out    (),
    .done_out    (settle_done)
  );
  fsrs_timer u_unload (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (tick),
    .start_in    (unload_go),
    .cancel_in   (st_r == fsrs_pkg::fsrs_st_cmd),
    .load_in     (unload_ms_in),
    .busy_out    (),
    .done_out    (unload_done)
  );

  // Sector data queue; a full queue while delivering counts as overrun
  fsrs_fifo #(.WIDTH(8), .DEPTH(`FSRS_FIFO_DEPTH)) u_fifo (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .f           (ff.fifo)
  );
  assign ff.wr_data  = dat_byte_in;
  assign ff.rd_ready = host_rd_in;

  // Sequencer next state
  always_comb begin
    st_nxt = st_r;       cmd0_nxt = cmd0_r;  sel_nxt = sel_r;
    cyl_nxt = cyl_r;     hd_nxt = hd_r;      sec_nxt = sec_r;
    size_nxt = size_r;   eot_nxt = eot_r;    dtl_nxt = dtl_r;
    idx_nxt = idx_r;     res_nxt = res_r;    bcnt_nxt = bcnt_r;
    ic_nxt = ic_r;       seek_end_nxt = seek_end_r;
    st1_nxt = st1_r;     st2_nxt = st2_r;    found_nxt = found_r;
    halt_nxt = halt_r;   stop_nxt = stop_r;  idxc_nxt = idxc_r;
    loaded_nxt = loaded_r;
    seek_req = 1'b0;     settle_go = 1'b0;   unload_go = 1'b0;
    ff.wr_valid = 1'b0;
    deliver = 1'b0;
    if (unload_done) loaded_nxt = 1'b0;
    case (st_r)
      fsrs_pkg::fsrs_st_idle: begin
        if (cmd_wr_in) begin
          cmd0_nxt = cmd_byte_in;
          idx_nxt  = 4'h1;
          st_nxt   = fsrs_pkg::fsrs_st_cmd;
        end
      end
      fsrs_pkg::fsrs_st_cmd: begin
        if (cmd_wr_in) begin
          case (idx_r)
            4'h1: sel_nxt  = cmd_byte_in;
            4'h2: cyl_nxt  = cmd_byte_in;
            4'h3: hd_nxt   = cmd_byte_in;
            4'h4: sec_nxt  = cmd_byte_in;
            4'h5: size_nxt = cmd_byte_in;
            4'h6: eot_nxt  = cmd_byte_in;
            4'h8: dtl_nxt  = cmd_byte_in;
            default: ;
          endcase
          idx_nxt = idx_r + 4'h1;
          if (idx_r == `FSRS_CMD_LEN - 4'h1) begin
            ic_nxt = 2'h0;  seek_end_nxt = 1'b0;
            st1_nxt = 8'h00; st2_nxt = 8'h00;
            stop_nxt = 1'b0; halt_nxt = 1'b0; found_nxt = 1'b0;
            idxc_nxt = 1'b0;
            if (implied_seek_en_in && cyl_r != seek_cur_cyl_in) begin
              seek_req = 1'b1;
              st_nxt   = fsrs_pkg::fsrs_st_seek;
            end else if (loaded_r && !unload_done) begin
              st_nxt = fsrs_pkg::fsrs_st_search;
            end else begin
              loaded_nxt = 1'b1;
              settle_go  = 1'b1;
              st_nxt     = fsrs_pkg::fsrs_st_settle;
            end
          end
        end
      end
      fsrs_pkg::fsrs_st_seek: begin
        if (seek_done_in) begin
          if (seek_fail_in) begin
            ic_nxt       = `FSRS_IC_ABN;
            seek_end_nxt = 1'b1;
            cyl_nxt      = seek_cur_cyl_in;
            st_nxt       = fsrs_pkg::fsrs_st_result;
            res_nxt      = 3'h0;
          end else if (loaded_r) begin
            st_nxt = fsrs_pkg::fsrs_st_search;
          end else begin
            loaded_nxt = 1'b1;
            settle_go  = 1'b1;
            st_nxt     = fsrs_pkg::fsrs_st_settle;
          end
        end
      end
      fsrs_pkg::fsrs_st_settle: begin
        if (settle_done) st_nxt = fsrs_pkg::fsrs_st_search;
      end
      fsrs_pkg::fsrs_st_search: begin
        if (idx_edge) begin
          idxc_nxt = 1'b1;
          if (idxc_r) begin
            ic_nxt = `FSRS_IC_ABN;
            st1_nxt[`FSRS_ST1_ND] = 1'b1;
            st_nxt = fsrs_pkg::fsrs_st_result;
          end
        end
        if (id_valid_in && st_nxt == fsrs_pkg::fsrs_st_search) begin
          found_nxt = 1'b0;
          if (!id_crc_ok_in) begin
            ic_nxt = `FSRS_IC_ABN;
            st1_nxt[`FSRS_ST1_DE] = 1'b1;
            st2_nxt[`FSRS_ST2_DD] = 1'b1;
            st_nxt = fsrs_pkg::fsrs_st_result;
          end else if (id_cyl_in == cyl_r && id_head_in == hd_r &&
                       id_sec_in == sec_r && id_size_in == size_r) begin
            found_nxt = 1'b1;
          end
        end
        if (dam_valid_in && found_r) begin
          found_nxt = 1'b0;
          bcnt_nxt  = 15'h0000;
          idxc_nxt  = 1'b0;
          if (dam_deleted_in != want_del) begin
            st2_nxt[`FSRS_ST2_CM] = 1'b1;
            if (sk) begin
              st_nxt = fsrs_pkg::fsrs_st_skip;
            end else begin
              halt_nxt = 1'b1;
              st_nxt   = fsrs_pkg::fsrs_st_data;
            end
          end else begin
            st_nxt = fsrs_pkg::fsrs_st_data;
          end
        end
        if (st_nxt == fsrs_pkg::fsrs_st_result) res_nxt = 3'h0;
      end
      fsrs_pkg::fsrs_st_data, fsrs_pkg::fsrs_st_skip: begin
        if (tc_f_r && st_r == fsrs_pkg::fsrs_st_data) stop_nxt = 1'b1;
        if (dat_valid_in && st_r == fsrs_pkg::fsrs_st_data) begin
          deliver = !stop_r && !tc_f_r &&
                    (size_r != 8'h00 ||
                     bcnt_r < {7'h00, dtl_r});
          if (deliver) begin
            if (ff.wr_ready) begin
              ff.wr_valid = 1'b1;
            end else begin
              stop_nxt = 1'b1;
              st1_nxt[`FSRS_ST1_OR] = 1'b1;
            end
          end
          if (bcnt_r != sec_bytes) bcnt_nxt = bcnt_r + 15'h0001;
        end
        if (dat_end_in) begin
          res_nxt = 3'h0;
          st_nxt  = fsrs_pkg::fsrs_st_result;
          if (!dat_crc_ok_in && st_r == fsrs_pkg::fsrs_st_data) begin
            ic_nxt = `FSRS_IC_ABN;
            st1_nxt[`FSRS_ST1_DE] = 1'b1;
          end else if (!halt_r) begin
            if (sec_r == eot_r) begin
              sec_nxt = `FSRS_SEC_FIRST;
              if (mt) hd_nxt = {hd_r[7:1], ~hd_r[0]};
              if (mt && !hd_r[0]) begin
                if (!stop_nxt) st_nxt = fsrs_pkg::fsrs_st_search;
              end else begin
                cyl_nxt = cyl_r + 8'h01;
                if (!stop_nxt) begin
                  ic_nxt = `FSRS_IC_ABN;
                  st1_nxt[`FSRS_ST1_EN] = 1'b1;
                end
              end
            end else begin
              sec_nxt = sec_r + 8'h01;
              if (!stop_nxt) st_nxt = fsrs_pkg::fsrs_st_search;
            end
          end
        end
      end
      fsrs_pkg::fsrs_st_result: begin
        if (host_rd_in && !ff.rd_valid) begin
          res_nxt = res_r + 3'h1;
          if (res_r == `FSRS_RES_LAST) st_nxt = fsrs_pkg::fsrs_st_idle;
        end
      end
      default: st_nxt = fsrs_pkg::fsrs_st_idle;
    endcase
    if (st_nxt == fsrs_pkg::fsrs_st_result &&
        st_r != fsrs_pkg::fsrs_st_result && loaded_nxt)
      unload_go = 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= fsrs_pkg::fsrs_st_idle;
      cmd0_r <= 8'h00;  sel_r <= 8'h00;  cyl_r <= 8'h00;
      hd_r <= 8'h00;    sec_r <= 8'h00;  size_r <= 8'h00;
      eot_r <= 8'h00;   dtl_r <= 8'h00;  idx_r <= 4'h0;
      res_r <= 3'h0;    bcnt_r <= 15'h0000;
      ic_r <= 2'h0;     seek_end_r <= 1'b0;
      st1_r <= 8'h00;   st2_r <= 8'h00;
      found_r <= 1'b0;  halt_r <= 1'b0;  stop_r <= 1'b0;
      idxc_r <= 1'b0;   loaded_r <= 1'b0;
      pre_r <= 15'h0000;
      idx_sy_r <= 3'h0; tc_sy_r <= 3'h0;
      idx_f_r <= 1'b0;  tc_f_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmd0_r <= cmd0_nxt; sel_r <= sel_nxt;  cyl_r <= cyl_nxt;
      hd_r <= hd_nxt;     sec_r <= sec_nxt;  size_r <= size_nxt;
      eot_r <= eot_nxt;   dtl_r <= dtl_nxt;  idx_r <= idx_nxt;
      res_r <= res_nxt;   bcnt_r <= bcnt_nxt;
      ic_r <= ic_nxt;     seek_end_r <= seek_end_nxt;
      st1_r <= st1_nxt;   st2_r <= st2_nxt;
      found_r <= found_nxt; halt_r <= halt_nxt; stop_r <= stop_nxt;
      idxc_r <= idxc_nxt; loaded_r <= loaded_nxt;
      pre_r <= pre_nxt;
      idx_sy_r <= {idx_sy_r[1:0], index_pulse_in};
      tc_sy_r  <= {tc_sy_r[1:0], terminal_count_in};
      idx_f_r  <= idx_f_nxt;
      tc_f_r   <= tc_f_nxt;
    end
  end

  // Result byte selection: status zero, one, two, then C, H, R, N
  always_comb begin
    case (res_r)
      3'h0: res_byte = status_reg_zero_out;
      3'h1: res_byte = st1_r;
      3'h2: res_byte = st2_r;
      3'h3: res_byte = cyl_r;
      3'h4: res_byte = hd_r;
      3'h5: res_byte = sec_r;
      default: res_byte = size_r;
    endcase
  end

  // Queued data drains before the result bytes so nothing is stranded
  assign host_data_out  = ff.rd_valid ? ff.rd_data : res_byte;
  assign host_rqm_out   = ff.rd_valid ||
                          (st_r == fsrs_pkg::fsrs_st_result);
  assign cmd_busy_out   = (st_r != fsrs_pkg::fsrs_st_idle);
  assign drive_busy_out = (st_r == fsrs_pkg::fsrs_st_seek) ?
                          (4'h1 << sel_r[1:0]) : 4'h0;
  assign head_load_out  = loaded_r;
  assign seek_req_out   = seek_req;
  assign seek_cyl_out   = cyl_r;
  assign status_reg_zero_out = {ic_r, seek_end_r, 2'h0, hd_r[0],
                                sel_r[1:0]};
  assign status_reg_one_out  = st1_r;
  assign status_reg_two_out  = st2_r;
endmodule // fsrs_seq

// File: src/fsrs_timer.sv
// Millisecond down-counter for head settle and unload intervals
`timescale 1ns/1ns
module fsrs_timer (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  // Control
  input  wire logic       tick_in,
  input  wire logic       start_in,
  input  wire logic       cancel_in,
  input  wire logic [7:0] load_in,
  // Status
  output logic            busy_out,
  output logic            done_out
);
  logic [7:0] cnt_r, cnt_nxt;
  logic       busy_r, busy_nxt, done_r, done_nxt;

  // Count ticks; a load of zero expires on the next cycle
  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start_in) begin
      cnt_nxt  = load_in;
      busy_nxt = 1'b1;
    end else if (cancel_in) begin
      busy_nxt = 1'b0;
    end else if (busy_r) begin
      if (cnt_r == 8'h00) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else if (tick_in) begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r  <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_out = busy_r;
  assign done_out = done_r;
endmodule // fsrs_timer

// File: tb/floppy_sector_read_sequencer_bench.sv
// Self-checking bench for the sector read sequencer
`timescale 1ns/1ns
`include "fsrs_map.svh"
module floppy_sector_read_sequencer_bench;
  logic clk = 1'b0, rst_n = 1'b0, cw = 1'b0, hrd = 1'b0, ise = 1'b0;
  logic sdone = 1'b0, sfail = 1'b0, rqm, busy, hload, sreq, idx, idv;
  logic idok, damv, damd, dv, de, dok;
  logic [7:0] cb = 8'h00, ccyl = 8'h00, hdata, db, st0, st1, st2, scyl;
  logic [3:0] dbusy;
  logic [31:0] idf;
  logic [7:0] got [$];
  int seed = 28427, fail_count = 0, checks_done = 0, n, k;
  bit drain = 1'b1;
  always #20 clk = ~clk;
  fsrs_seq #(.TICK_CYC(4)) dut_u (.core_clk_in(clk), .arst_n_in(rst_n),
    .cmd_wr_in(cw), .cmd_byte_in(cb), .host_rd_in(hrd),
    .host_data_out(hdata), .host_rqm_out(rqm), .cmd_busy_out(busy),
    .drive_busy_out(dbusy), .implied_seek_en_in(ise),
    .settle_ms_in(8'h01), .unload_ms_in(8'h01), .index_pulse_in(idx),
    .terminal_count_in(1'b0), .head_load_out(hload), .seek_req_out(sreq),
    .seek_cyl_out(scyl), .seek_done_in(sdone), .seek_fail_in(sfail),
    .seek_cur_cyl_in(ccyl), .id_valid_in(idv), .id_crc_ok_in(idok),
    .id_cyl_in(idf[31:24]), .id_head_in(idf[23:16]),
    .id_sec_in(idf[15:8]), .id_size_in(idf[7:0]), .dam_valid_in(damv),
    .dam_deleted_in(damd), .dat_valid_in(dv), .dat_byte_in(db),
    .dat_end_in(de), .dat_crc_ok_in(dok), .status_reg_zero_out(st0),
    .status_reg_one_out(st1), .status_reg_two_out(st2));
  fsrs_drive_model drv_u (.core_clk_in(clk), .index_pulse_out(idx),
    .id_valid_out(idv), .id_crc_ok_out(idok), .id_out(idf),
    .dam_valid_out(damv), .dam_deleted_out(damd), .dat_valid_out(dv),
    .dat_byte_out(db), .dat_end_out(de), .dat_crc_ok_out(dok));
  // Host reads every other cycle so a stale request never double-pops
  always @(posedge clk) begin
    if (hrd) got.push_back(hdata);
    hrd <= drain && rqm && !hrd;
  end
  // Bytes handed over per sector for a size code and data length
  function automatic int deliver(input int sz, data_length);
    return (sz == 0 && data_length < 128) ? data_length : 128 << sz;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cut(input string what);
    fail_count++;
    $display("FAIL %s expected done seen timeout", what);
    tally_and_finish();
  endtask
  // Nine bytes back to back
  task automatic send_cmd(input logic [7:0] b [9]);
    got.delete();
    foreach (b[i]) begin
      @(posedge clk) cw <= 1'b1;
      cb <= b[i];
    end
    @(posedge clk) cw <= 1'b0;
    cb <= 8'hA5;
  endtask
  // Command, then wait for head load and settle before fields pass
  task automatic go(input logic [7:0] b [9]);
    send_cmd(b);
    for (n = 0; hload !== 1'b1 && n < 100; n++) @(posedge clk);
    if (n == 100) cut("head load");
    repeat (16) @(posedge clk);
  endtask
  task automatic done(input string name);
    for (n = 0; busy !== 1'b0 && n < 20000; n++) @(posedge clk);
    if (n == 20000) cut(name);
    $display("test %s finished", name);
  endtask
  task automatic check_data(input int cnt, per);
    check("byte count", got.size() - 7, cnt);
    for (int i = 0; i < cnt && i < got.size(); i++)
      check("data byte", got[i], drv_u.mem[i % per]);
  endtask
  task automatic check_res(input logic [7:0] e [7], input logic [6:0] m);
    for (int i = 0; i < 7; i++)
      if (m[i]) check("result", got[got.size() - 7 + i], e[i]);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) drv_u.mem[i] = $random(seed);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Two sectors up to the last one, random short data length
    n = 1 + {$random(seed)} % 127;
    k = n;
    go('{8'h06, 8'h00, 8'h05, 8'h00, 8'h03, 8'h00, 8'h04, 8'h1B, k[7:0]});
    drv_u.sector(32'h0500_0300, 1'b1, 1'b0, 128);
    drv_u.sector(32'h0500_0400, 1'b1, 1'b0, 128);
    done("two_sectors");
    check_data(2 * deliver(0, k), k);
    check_res('{8'h40, 8'h80, 8'h00, 8'h06, 8'h00, 8'h01, 8'h00},
              7'h7F);
    // Mark mismatch: stalled host overrun, drained halt, bypass skip
    for (k = 0; k < 3; k++) begin
      drain = (k != 0);
      go('{(k == 2) ? 8'h26 : 8'h0C, 8'h00, 8'h05, 8'h00, 8'h03, 8'h01,
           8'h03, 8'h1B, 8'hFF});
      drv_u.sector(32'h0500_0301, 1'b1, k == 2, 256);
      drain = 1'b1;
      done("marks");
      check_data(k == 2 ? 0 : k ? deliver(1, 255) : `FSRS_FIFO_DEPTH,
                 256);
      check("control mark", st2[6], 1'b1);
      check("overrun", st1[4], k == 0);
      check("sector", got[got.size() - 2], k == 2 ? 1 : 3);
    end
    // Sector never found, then a bad ID field
    for (k = 0; k < 2; k++) begin
      go('{8'h06, 8'h00, 8'h05, 8'h00, 8'h07, 8'h00, 8'h09, 8'h1B, 8'h80});
      if (k == 0) repeat (3) drv_u.spin_index();
      else drv_u.sector(32'h0500_0700, 1'b0, 1'b0, 0);
      done("faults");
      check("abnormal", st0[7:6], 2'h1);
      check("flags", {st1[5], st1[2], st2[5]}, k ? 5 : 2);
    end
    // Implied seek on drive two fails at cylinder two
    ise <= 1'b1;
    ccyl <= 8'h02;
    send_cmd('{8'h06, 8'h02, 8'h09, 8'h00, 8'h01, 8'h00, 8'h09, 8'h1B,
               8'hFF});
    @(negedge clk) check("drive busy", dbusy, 4'h4);
    check("seek cylinder", scyl, 8'h09);
    @(posedge clk) {sdone, sfail} <= 2'h3;
    @(posedge clk) {sdone, sfail, ise} <= 3'h0;
    done("seek");
    check_res('{8'h62, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00},
              7'h09);
    tally_and_finish();
  end
endmodule // floppy_sector_read_sequencer_bench

// File: tb/fsrs_drive_model.sv
// Behavioural drive: index hole and decoded field strobes
`timescale 1ns/1ns
module fsrs_drive_model (
  // Clock
  input  wire logic core_clk_in,
  // Drive strobes
  output logic        index_pulse_out,
  output logic        id_valid_out,
  output logic        id_crc_ok_out,
  output logic [31:0] id_out,
  output logic        dam_valid_out,
  output logic        dam_deleted_out,
  output logic        dat_valid_out,
  output logic [7:0]  dat_byte_out,
  output logic        dat_end_out,
  output logic        dat_crc_ok_out
);
  logic [7:0] mem [0:255]; // Sector contents, loaded by the bench
  initial begin
    {index_pulse_out, id_valid_out, id_crc_ok_out, dam_valid_out} = '0;
    {dam_deleted_out, dat_valid_out, dat_end_out, dat_crc_ok_out} = '0;
    id_out = '0;
    dat_byte_out = '0;
  end
  // Index held several cycles so the pin synchroniser sees it
  task automatic spin_index();
    @(posedge core_clk_in) index_pulse_out <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    index_pulse_out <= 1'b0;
    repeat (20) @(posedge core_clk_in);
  endtask
  // One sector; a bad ID ends it, fields show garbage between strobes
  task automatic sector(input logic [31:0] id, input logic ok, del,
                        input int len);
    @(posedge core_clk_in) id_valid_out <= 1'b1;
    id_out <= id;
    id_crc_ok_out <= ok;
    @(posedge core_clk_in) id_valid_out <= 1'b0;
    id_out <= ~id;
    if (ok) begin
      dam_valid_out <= 1'b1;
      dam_deleted_out <= del;
      @(posedge core_clk_in) dam_valid_out <= 1'b0;
      for (int i = 0; i < len; i++) begin
        dat_valid_out <= 1'b1;
        dat_byte_out <= mem[i];
        @(posedge core_clk_in) dat_valid_out <= 1'b0;
        dat_byte_out <= ~mem[i];
        repeat (2) @(posedge core_clk_in);
      end
      {dat_end_out, dat_crc_ok_out} <= 2'h3;
      @(posedge core_clk_in) {dat_end_out, dat_crc_ok_out} <= 2'h0;
    end
  endtask
endmodule // fsrs_drive_model

// File: tb/fsrs_seq_chk.sv
// Port assertions for the sector read sequencer
`timescale 1ns/1ns
module fsrs_seq_chk (
  // Clock and reset
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  // Host side
  input wire logic       cmd_wr_in,
  input wire logic       cmd_busy_out,
  input wire logic       host_rqm_out,
  // Seek side
  input wire logic       implied_seek_en_in,
  input wire logic [3:0] drive_busy_out,
  input wire logic       seek_req_out,
  input wire logic       seek_done_in,
  // Status
  input wire logic [7:0] status_reg_zero_out,
  input wire logic [7:0] status_reg_one_out,
  input wire logic [7:0] status_reg_two_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Busy for exactly one drive appears with or one cycle after the seek request
  sequence s_one_busy;
    ##[0:1] $onehot(drive_busy_out);
  endsequence
  AST_SEEK_BUSY: assert property (seek_req_out |-> s_one_busy)
    else $error("no drive busy during seek");
  AST_SEEK_END: assert property ((drive_busy_out != 4'h0) && seek_done_in
    |=> drive_busy_out == 4'h0)
    else $error("drive busy outlived seek");
  AST_SEEK_EN: assert property (seek_req_out |-> implied_seek_en_in)
    else $error("seek without enable");
  AST_SEEK_PULSE: assert property (seek_req_out |=> !seek_req_out)
    else $error("seek request too long");
  AST_CMD_START: assert property (cmd_wr_in && !cmd_busy_out
    |=> cmd_busy_out)
    else $error("first byte not taken");
  AST_IDLE_RQM: assert property (!cmd_busy_out |-> !host_rqm_out)
    else $error("read request while idle");
  AST_ND_CODE: assert property ($rose(status_reg_one_out[2])
    |-> ##[0:1] status_reg_zero_out[7:6] == 2'h1)
    else $error("no data without abnormal code");
  AST_DD_DE: assert property (status_reg_two_out[5]
    |-> status_reg_one_out[5])
    else $error("id crc flag without data error");
endmodule // fsrs_seq_chk

bind fsrs_seq fsrs_seq_chk chk_u (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .cmd_wr_in(cmd_wr_in),
  .cmd_busy_out(cmd_busy_out), .host_rqm_out(host_rqm_out),
  .implied_seek_en_in(implied_seek_en_in),
  .drive_busy_out(drive_busy_out), .seek_req_out(seek_req_out),
  .seek_done_in(seek_done_in), .status_reg_zero_out(status_reg_zero_out),
  .status_reg_one_out(status_reg_one_out),
  .status_reg_two_out(status_reg_two_out));
